// file: core/i2c_rx_pkg.sv
// Package: constants, states and carrier types of the I2C slave receiver
package i2c_rx_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] STATUS_WMASK = 8'hc0;
  localparam int ST_BF = 0;
  localparam int ST_RW = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_DA = 5;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA,
    PH_ACK,
    PH_IGNORE
  } phase_t;

  typedef struct packed {
    logic clock_stretch_enable;
    logic address_hold_enable;
    logic data_hold_enable;
    logic buffer_overwrite_enable;
    logic start_irq_enable;
    logic stop_irq_enable;
    logic spi_master_mode;
    logic [ADDR_W-1:0] own_address;
  } cfg_t;

  typedef struct packed {
    logic is_addr;
    logic [BYTE_W-1:0] data;
  } rx_word_t;
endpackage

// file: core/i2c_slave_rx.sv
// I2C slave receiver with shared byte buffer and shift register
`timescale 1ns/1ps
`default_nettype none
// Function
// - Status low six bits read-only; upper two bits software writable.
// - In SPI master mode the address register value reloads the baud divider.
// - Completed byte moves into data buffer and sets serial interrupt flag.
// - Software write to buffer loads buffer and shift register together.
// - Matching address with write direction clears rw bit, loads buffer, acks.
// - Buffer full or overflow at address gives NACK unless overwrite enabled.
// - Interrupt flag set per transferred byte; software clears it.
// - With stretch enabled, hold SCL low after each acked byte until release bit set.
// - Start sets start bit; interrupt flag only if start interrupt enabled.
// - After matching address, drive SDA low in ack bit and set flag.
// - Reading data buffer clears buffer-full flag.
// - Stop sets stop bit and returns bus to idle.
// - With hold enabled, set flag and clear release bit after 8th fall.
// - Ack-phase flag tells whether interrupt is before or after the ack.
// - When holding, ack bit driven with software ack value after release.
// - Flag set after 9th fall when ACK sent, never on NACK.
// - With hold and stretch, also stretch SCL after the ack bit.
// - Transfer ends on NACK from slave or Stop from master.
module i2c_slave_rx
  import i2c_rx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire i2c_rx_pkg::cfg_t cfg,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  output logic [7:0] buf_rdata,
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  output logic [7:0] status_rdata,
  input wire logic irq_clr,
  output logic serial_irq_flag,
  input wire logic release_set,
  output logic clock_release_bit,
  input wire logic ack_value_bit,
  output logic ack_phase_flag,
  output logic buffer_full_flag,
  input wire logic ovf_clr,
  output logic receive_overflow_flag,
  input wire logic [7:0] baud_wdata,
  input wire logic baud_wr,
  output logic baud_reload_r,
  output logic rx_valid,
  input wire logic rx_ready,
  output i2c_rx_pkg::rx_word_t rx_word
);
  import i2c_rx_pkg::*;

  // ----------------------------------------
  // Bus edge detection
  // ----------------------------------------
  logic scl_q_r, sda_q_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end
  wire logic scl_rise = scl_in & ~scl_q_r;
  wire logic scl_fall = ~scl_in & scl_q_r;
  wire logic start_ev = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire logic stop_ev = scl_in & scl_q_r & ~sda_q_r & sda_in;

  // ----------------------------------------
  // Receive sequencer
  // ----------------------------------------
  phase_t phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] byte_shift_reg;
  logic [7:0] data_buffer_reg;
  logic [7:0] baud_reg_r;
  logic [7:0] status_hi_r;
  logic rw_r, start_r, stop_r, da_r, addr_byte_r, nack_r, hold_r, post_ack_r;
  logic fifo_ready, accept_r, release_q_r;

  function automatic logic addr_match(input logic [7:0] b, input logic [6:0] own);
    addr_match = (b[7:1] == own);
  endfunction

  wire logic byte_done = (phase_r == PH_ADDR || phase_r == PH_DATA) && scl_fall && bit_cnt_r == BIT_LAST;
  wire logic [7:0] byte_now = byte_shift_reg;
  wire logic is_match = addr_match(byte_now, cfg.own_address) && ~byte_now[0];
  wire logic blocked = (buffer_full_flag | receive_overflow_flag) & ~cfg.buffer_overwrite_enable;
  wire logic hold_now = (phase_r == PH_ADDR) ? cfg.address_hold_enable : cfg.data_hold_enable;
  wire logic accept = (phase_r == PH_DATA || is_match) && !blocked;
  wire logic ack_fall = phase_r == PH_ACK && scl_fall;
  wire logic ack_sent = ack_fall && !nack_r;
  wire logic buf_load = ack_sent && (hold_r || accept_r);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= PH_IDLE;
      bit_cnt_r <= 4'h0;
      byte_shift_reg <= BUF_RST;
      addr_byte_r <= 1'b0;
      nack_r <= 1'b0;
      hold_r <= 1'b0;
      accept_r <= 1'b0;
    end else if (start_ev) begin
      phase_r <= PH_ADDR;
      bit_cnt_r <= 4'h0;
    end else if (stop_ev) begin
      phase_r <= PH_IDLE;
    end else if (buf_wr) begin
      byte_shift_reg <= buf_wdata;
    end else begin
      // Bits are counted on rises, so the SCL fall that follows a Start is not taken for a bit
      if (scl_rise && (phase_r == PH_ADDR || phase_r == PH_DATA)) begin
        byte_shift_reg <= {byte_shift_reg[6:0], sda_in};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (byte_done) begin
        addr_byte_r <= phase_r == PH_ADDR;
        hold_r <= hold_now;
        accept_r <= accept;
        nack_r <= hold_now ? 1'b0 : !accept;
        if (phase_r == PH_ADDR && !is_match) begin
          phase_r <= PH_IGNORE;
        end else begin
          phase_r <= PH_ACK;
        end
      end
      // Software decides the answer while holding; value latched at release
      if (hold_r && release_set && phase_r == PH_ACK) begin
        nack_r <= ack_value_bit;
      end
      if (ack_fall) begin
        bit_cnt_r <= 4'h0;
        phase_r <= nack_r ? PH_IGNORE : PH_DATA;
      end
    end
  end

  // ----------------------------------------
  // Buffer, status and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      data_buffer_reg <= BUF_RST;
      buffer_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
    end else begin
      if (buf_wr) begin
        data_buffer_reg <= buf_wdata;
      end else if (buf_load) begin
        data_buffer_reg <= byte_now;
      end
      if (buf_load && fifo_ready) begin
        buffer_full_flag <= 1'b1;
      end else if (buf_rd) begin
        buffer_full_flag <= 1'b0;
      end
      if ((byte_done && buffer_full_flag && phase_r == PH_DATA) || (buf_load && !fifo_ready)) begin
        receive_overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        receive_overflow_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rw_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      da_r <= 1'b0;
      status_hi_r <= STATUS_RST;
    end else begin
      if (status_wr) begin
        status_hi_r <= status_wdata & STATUS_WMASK;
      end
      if (start_ev) begin
        start_r <= 1'b1;
        stop_r <= 1'b0;
      end else if (stop_ev) begin
        stop_r <= 1'b1;
        start_r <= 1'b0;
      end
      if (byte_done && phase_r == PH_ADDR && is_match) begin
        rw_r <= 1'b0;
      end
      if (buf_load) begin
        da_r <= !addr_byte_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_irq_flag <= 1'b0;
      ack_phase_flag <= 1'b0;
      post_ack_r <= 1'b0;
    end else begin
      // Hardware set wins over a software clear in the same cycle
      if ((start_ev && cfg.start_irq_enable) || (stop_ev && cfg.stop_irq_enable)
          || (byte_done && hold_now && (phase_r == PH_DATA || is_match))
          || ack_sent) begin
        serial_irq_flag <= 1'b1;
      end else if (irq_clr) begin
        serial_irq_flag <= 1'b0;
      end
      if (byte_done) begin
        ack_phase_flag <= 1'b1;
      end else if (ack_fall) begin
        ack_phase_flag <= 1'b0;
      end
      post_ack_r <= ack_sent;
    end
  end

  // ----------------------------------------
  // Clock stretch and bus drivers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_release_bit <= 1'b1;
      release_q_r <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      if (release_set) begin
        clock_release_bit <= 1'b1;
      end else if (byte_done && (hold_now && (phase_r == PH_DATA || is_match))) begin
        clock_release_bit <= 1'b0;
      end else if (ack_sent && cfg.clock_stretch_enable) begin
        clock_release_bit <= 1'b0;
      end
      release_q_r <= release_set;
      // SCL is let go one cycle after SDA takes the answer, so SDA never moves while SCL is high
      scl_oe <= (!clock_release_bit || release_q_r) && phase_r != PH_IDLE && !scl_in;
      sda_oe <= phase_r == PH_ACK && !nack_r && !(hold_r && !clock_release_bit);
    end
  end

  // ----------------------------------------
  // Baud reload (SPI master reuse)
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      baud_reg_r <= BAUD_RST;
      baud_reload_r <= 1'b0;
    end else begin
      if (baud_wr) begin
        baud_reg_r <= baud_wdata;
      end
      baud_reload_r <= cfg.spi_master_mode && baud_wr;
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  rx_word_t fifo_mem [FIFO_DEPTH];
  logic wr_ptr_r, rd_ptr_r;
  logic [1:0] count_r;
  assign fifo_ready = count_r != 2'(FIFO_DEPTH);
  wire logic push = buf_load && fifo_ready;
  wire logic pop = rx_valid && rx_ready;
  rx_word_t push_word;
  assign push_word = '{is_addr: addr_byte_r, data: byte_now};

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      rx_valid <= 1'b0;
      rx_word <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_r] <= push_word;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + 2'(push) - 2'(pop);
      rx_valid <= (count_r + 2'(push) - 2'(pop)) != 2'h0 && !(count_r == 2'h0 && push);
      // A push and a pop with one word held hit the same slot: forward the new word
      if (push && pop && count_r == 2'h1) begin
        rx_word <= push_word;
      end else begin
        rx_word <= fifo_mem[pop ? ~rd_ptr_r : rd_ptr_r];
      end
    end
  end

  assign buf_rdata = data_buffer_reg;
  // Status is registered, so it shows a change one cycle after its source bits
  always_ff @(posedge clk) begin
    if (srst) begin
      status_rdata <= STATUS_RST;
    end else begin
      status_rdata <= {status_hi_r[7:6], da_r, stop_r, start_r, rw_r, 1'b0, buffer_full_flag};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_irq_sticky: assert property (@(posedge clk) disable iff (srst)
    serial_irq_flag && !irq_clr |=> serial_irq_flag) else $error("irq flag dropped");
  chk_ack_sda: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_ACK && !nack_r && !hold_r |=> sda_oe || phase_r != PH_ACK) else $error("ack not driven");
  chk_bf_clear: assert property (@(posedge clk) disable iff (srst)
    buf_rd && !buf_load |=> !buffer_full_flag) else $error("bf not cleared");
  chk_stop_idle: assert property (@(posedge clk) disable iff (srst)
    stop_ev && !start_ev |=> stop_r && phase_r == PH_IDLE) else $error("stop missed");
  chk_start_bit: assert property (@(posedge clk) disable iff (srst)
    start_ev |=> start_r && phase_r == PH_ADDR) else $error("start missed");
  chk_ovf_sticky: assert property (@(posedge clk) disable iff (srst)
    receive_overflow_flag && !ovf_clr |=> receive_overflow_flag) else $error("ovf dropped");
  chk_nack_no_irq: assert property (@(posedge clk) disable iff (srst)
    ack_fall && nack_r && !serial_irq_flag && !start_ev && !stop_ev |=> !serial_irq_flag) else $error("irq on nack");
  chk_hold_stretch: assert property (@(posedge clk) disable iff (srst)
    byte_done && hold_now && !release_set && (phase_r == PH_DATA || is_match) |=> !clock_release_bit && serial_irq_flag)
    else $error("hold not taken");
  chk_ack_phase: assert property (@(posedge clk) disable iff (srst)
    byte_done |=> ack_phase_flag) else $error("ack phase");
  chk_ack_stretch: assert property (@(posedge clk) disable iff (srst)
    ack_sent && cfg.clock_stretch_enable && !release_set |=> !clock_release_bit) else $error("no stretch after ack");
  chk_ack_irq: assert property (@(posedge clk) disable iff (srst)
    post_ack_r |-> serial_irq_flag) else $error("no irq after ack");
  cov_start: cover property (@(posedge clk) disable iff (srst) start_ev);
  cov_ack: cover property (@(posedge clk) disable iff (srst) ack_sent);
  cov_full: cover property (@(posedge clk) disable iff (srst) !fifo_ready);
  cov_stop: cover property (@(posedge clk) disable iff (srst) stop_ev);
endmodule
`default_nettype wire

// file: sim/i2c_master_model.sv
// Behavioural I2C bus master that writes bytes to the slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clk,
  input wire logic scl_bus,
  input wire logic sda_bus,
  output logic scl_low,
  output logic sda_low,
  output logic stall_err
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stall_err = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge clk);
  endtask
  // The slave may stretch; wait for the wire, but never forever
  task automatic scl_up();
    int n;
    n = 0;
    scl_low = 1'b0;
    @(negedge clk);
    while (scl_bus !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (scl_bus !== 1'b1) stall_err = 1'b1;
    half();
  endtask
  task automatic start();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
    half();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl_up();
    sda_low = 1'b0;
    half();
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      half();
      scl_up();
      scl_low = 1'b1;
    end
    sda_low = 1'b0;
    half();
    scl_up();
    ack = sda_bus;
    scl_low = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// file: sim/tb_sync_serial_i2c_slave_rx.sv
// Self-checking bench for the I2C slave receiver
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_i2c_slave_rx;
  import i2c_rx_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl_out, scl_oe, sda_out, sda_oe, serial_irq_flag, clock_release_bit, ack_phase_flag;
  logic buffer_full_flag, receive_overflow_flag, baud_reload_r, rx_valid, m_scl, m_sda, m_err;
  logic [7:0] buf_rdata, status_rdata;
  logic buf_wr = 1'b0, buf_rd = 1'b0, status_wr = 1'b0, irq_clr = 1'b0, release_set = 1'b0;
  logic ack_value_bit = 1'b0, ovf_clr = 1'b0, baud_wr = 1'b0, rx_ready = 1'b0;
  logic [7:0] buf_wdata = 8'h00, status_wdata = 8'h00, baud_wdata = 8'h00;
  cfg_t cfg = '0;
  rx_word_t rx_word;
  rx_word_t got_q[$];
  int err_total = 0;
  int checked = 0;
  wire logic scl_w, sda_w;
  // Open-drain wires: pulled up unless a party pulls low
  assign scl_w = ~m_scl & ~(scl_oe & ~scl_out);
  assign sda_w = ~m_sda & ~(sda_oe & ~sda_out);
  always #50 clk = ~clk;
  always @(posedge clk) if (rx_valid && rx_ready) got_q.push_back(rx_word);
  // A stretch that outlasts the master's patience ends the run at once
  always @(posedge m_err) begin
    err_total++;
    final_report();
  end

  i2c_slave_rx u_i2c_slave_rx (.clk, .srst, .scl_in(scl_w), .sda_in(sda_w), .scl_out, .scl_oe,
    .sda_out, .sda_oe, .cfg, .buf_wr, .buf_wdata, .buf_rd, .buf_rdata, .status_wr, .status_wdata,
    .status_rdata, .irq_clr, .serial_irq_flag, .release_set, .clock_release_bit, .ack_value_bit,
    .ack_phase_flag, .buffer_full_flag, .ovf_clr, .receive_overflow_flag, .baud_wdata, .baud_wr,
    .baud_reload_r, .rx_valid, .rx_ready, .rx_word);
  i2c_master_model u_i2c_master_model (.clk, .scl_bus(scl_w), .sda_bus(sda_w), .scl_low(m_scl),
    .sda_low(m_sda), .stall_err(m_err));

  // ----
  // Helpers
  // ----
  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_val(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp_val(n, {8'h00, e}, {8'h00, g});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (serial_irq_flag !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (serial_irq_flag !== 1'b1) begin
      err_total++;
      final_report();
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] b, input logic e_ack);
    logic a;
    u_i2c_master_model.send(b, a);
    cmp_bit("ack", e_ack, a);
  endtask
  task automatic baud_pulses(output int c);
    c = 0;
    baud_wr = 1'b1;
    repeat (4) begin
      @(negedge clk);
      baud_wr = 1'b0;
      c += (baud_reload_r === 1'b1);
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic sc_regs();
    int c;
    cmp_bit("release", 1'b1, clock_release_bit);
    status_wdata = 8'hff;
    pulse(status_wr);
    // Status is registered: one more cycle before the write shows
    @(negedge clk);
    cmp_val("status", 9'h0c0, {1'b0, status_rdata});
    cfg.spi_master_mode = 1'b1;
    baud_wdata = 8'h5a;
    baud_pulses(c);
    cmp_val("baud", 9'h001, 9'(c));
    cfg.spi_master_mode = 1'b0;
    baud_pulses(c);
    cmp_val("baud", 9'h000, 9'(c));
    buf_wdata = 8'ha5;
    pulse(buf_wr);
    cmp_val("buf", 9'h0a5, {1'b0, buf_rdata});
  endtask
  task automatic sc_basic();
    logic a;
    cfg.own_address = 7'h2a;
    cfg.start_irq_enable = 1'b1;
    u_i2c_master_model.start();
    cmp_bit("start", 1'b1, status_rdata[ST_START]);
    cmp_bit("irq", 1'b1, serial_irq_flag);
    pulse(irq_clr);
    xfer(8'h54, 1'b0);
    cmp_bit("irq", 1'b1, serial_irq_flag);
    cmp_val("buf", 9'h054, {1'b0, buf_rdata});
    cmp_bit("rw", 1'b0, status_rdata[ST_RW]);
    cmp_bit("da", 1'b0, status_rdata[ST_DA]);
    cmp_bit("bf", 1'b1, buffer_full_flag);
    pulse(irq_clr);
    pulse(buf_rd);
    cmp_bit("bf", 1'b0, buffer_full_flag);
    xfer(8'h3c, 1'b0);
    cmp_val("buf", 9'h03c, {1'b0, buf_rdata});
    cmp_bit("da", 1'b1, status_rdata[ST_DA]);
    cmp_bit("irq", 1'b1, serial_irq_flag);
    pulse(irq_clr);
    u_i2c_master_model.send(8'hc3, a);
    cmp_bit("ovf", 1'b1, receive_overflow_flag);
    u_i2c_master_model.stop();
    cmp_bit("stop", 1'b1, status_rdata[ST_STOP]);
    cmp_bit("start", 1'b0, status_rdata[ST_START]);
    u_i2c_master_model.start();
    pulse(irq_clr);
    xfer(8'h54, 1'b1);
    cmp_bit("irq", 1'b0, serial_irq_flag);
    u_i2c_master_model.stop();
    rx_ready = 1'b1;
    repeat (4) @(negedge clk);
    cmp_val("count", 9'h002, 9'(got_q.size()));
    cmp_val("word", 9'h154, got_q[0]);
    cmp_val("word", 9'h03c, got_q[1]);
    cfg.buffer_overwrite_enable = 1'b1;
    u_i2c_master_model.start();
    xfer(8'h54, 1'b0);
    u_i2c_master_model.stop();
    cfg.buffer_overwrite_enable = 1'b0;
    pulse(ovf_clr);
    pulse(buf_rd);
    pulse(irq_clr);
    cmp_bit("ovf", 1'b0, receive_overflow_flag);
  endtask
  task automatic sc_ignore();
    cfg.start_irq_enable = 1'b0;
    u_i2c_master_model.start();
    cmp_bit("irq", 1'b0, serial_irq_flag);
    xfer(8'h56, 1'b1);
    u_i2c_master_model.stop();
    u_i2c_master_model.start();
    xfer(8'h55, 1'b1);
    u_i2c_master_model.stop();
    cmp_bit("irq", 1'b0, serial_irq_flag);
    cfg.stop_irq_enable = 1'b1;
    u_i2c_master_model.start();
    u_i2c_master_model.stop();
    cmp_bit("irq", 1'b1, serial_irq_flag);
    pulse(irq_clr);
    cfg.stop_irq_enable = 1'b0;
  endtask
  task automatic sc_hold();
    cfg.clock_stretch_enable = 1'b1;
    cfg.address_hold_enable = 1'b1;
    cfg.data_hold_enable = 1'b1;
    u_i2c_master_model.start();
    fork
      xfer(8'h54, 1'b0);
      begin
        wait_irq();
        cmp_bit("ackph", 1'b1, ack_phase_flag);
        cmp_bit("release", 1'b0, clock_release_bit);
        cmp_bit("stretch", 1'b1, scl_oe);
        pulse(irq_clr);
        pulse(buf_rd);
        pulse(release_set);
        wait_irq();
        cmp_bit("ackph", 1'b0, ack_phase_flag);
        cmp_bit("stretch", 1'b1, scl_oe);
        pulse(irq_clr);
        pulse(buf_rd);
        pulse(release_set);
      end
    join
    fork
      xfer(8'h99, 1'b1);
      begin
        wait_irq();
        ack_value_bit = 1'b1;
        pulse(irq_clr);
        pulse(release_set);
      end
    join
    repeat (2) @(negedge clk);
    cmp_bit("irq", 1'b0, serial_irq_flag);
    pulse(release_set);
    u_i2c_master_model.stop();
  endtask

  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    sc_regs();
    sc_basic();
    sc_ignore();
    sc_hold();
    cmp_bit("stall", 1'b0, m_err);
    final_report();
  end
endmodule
`default_nettype wire
